// *** hdl/tmz_pkg.sv ***
package tmz_pkg;

  // ----------------------------------------------------------------
  // register map (index times four gives the byte address)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 12;
  localparam logic [11:0] IDX_COUNT  = 12'h001;
  localparam logic [11:0] IDX_INTCTL = 12'h00b;
  localparam logic [11:0] IDX_OPTION = 12'h081;
  localparam logic [11:0] ADDR_COUNT  = {IDX_COUNT[9:0], 2'b00};
  localparam logic [11:0] ADDR_INTCTL = {IDX_INTCTL[9:0], 2'b00};
  localparam logic [11:0] ADDR_OPTION = {IDX_OPTION[9:0], 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned OPT_SRC_BIT  = 5;
  localparam int unsigned OPT_EDGE_BIT = 4;
  localparam int unsigned OPT_PSA_BIT  = 3;
  localparam int unsigned OPT_RATE_LSB = 0;
  localparam int unsigned RATE_W       = 3;
  localparam int unsigned INT_EN_BIT   = 5;
  localparam int unsigned INT_FLAG_BIT = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic       INT_EN_RST = 1'b0;

  // ----------------------------------------------------------------
  // timing and bus response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PHASE_Q2      = 2'h1;
  localparam logic [1:0] PHASE_Q4      = 2'h3;
  localparam logic [1:0] WRITE_HOLD_IC = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tmz_pkg

// *** hdl/tmz_timer0.sv ***
// The AXI4-Lite interface to the registers is this design's own decision.
module tmz_timer0 #(
  parameter int unsigned AW = tmz_pkg::ADDR_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output      logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output      logic          s_axi_wready,
  output      logic [1:0]    s_axi_bresp,
  output      logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output      logic          s_axi_arready,
  output      logic [31:0]   s_axi_rdata,
  output      logic [1:0]    s_axi_rresp,
  output      logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          external_count_input,
  input  wire logic          sleep,
  input  wire logic          watchdog_tick_in,
  input  wire logic          watchdog_clear_instruction,
  output      logic          watchdog_tick_out,
  output      logic          irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]    phase_q;
  logic [7:0]    count_q;
  logic [7:0]    option_q;
  logic          int_en_q;
  logic          flag_q;
  logic [7:0]    pre_q;
  logic          lvl_prev_q;
  logic          sync_q;
  logic [1:0]    hold_q;
  logic          wdt_out_q;
  logic          aw_q;
  logic          w_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          rvalid_q;
  logic [1:0]    rresp_q;
  logic [31:0]   rdata_q;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  localparam int unsigned RATE_W = tmz_pkg::RATE_W;
  logic              src_ext;
  logic              edge_fall;
  logic              prescaler_assign;
  logic [RATE_W-1:0] rate;

  assign src_ext   = option_q[tmz_pkg::OPT_SRC_BIT];
  assign edge_fall = option_q[tmz_pkg::OPT_EDGE_BIT];
  assign prescaler_assign       = option_q[tmz_pkg::OPT_PSA_BIT];
  assign rate      = option_q[tmz_pkg::OPT_RATE_LSB +: RATE_W];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic do_wr;
  logic wr_lane0;
  logic wr_count;
  logic wr_intctl;
  logic wr_option;
  logic wr_hit;
  logic rd_take;
  logic rd_hit;

  assign do_wr     = aw_q & w_q & ~bvalid_q;
  assign wr_lane0  = do_wr & wstrb_q[0];
  assign wr_count  = wr_lane0 & (awaddr_q == AW'(tmz_pkg::ADDR_COUNT));
  assign wr_intctl = wr_lane0 & (awaddr_q == AW'(tmz_pkg::ADDR_INTCTL));
  assign wr_option = wr_lane0 & (awaddr_q == AW'(tmz_pkg::ADDR_OPTION));
  assign wr_hit    = (awaddr_q == AW'(tmz_pkg::ADDR_COUNT))
                   | (awaddr_q == AW'(tmz_pkg::ADDR_INTCTL))
                   | (awaddr_q == AW'(tmz_pkg::ADDR_OPTION));
  assign rd_take   = s_axi_arvalid & ~rvalid_q;
  assign rd_hit    = (s_axi_araddr == AW'(tmz_pkg::ADDR_COUNT))
                   | (s_axi_araddr == AW'(tmz_pkg::ADDR_INTCTL))
                   | (s_axi_araddr == AW'(tmz_pkg::ADDR_OPTION));

  // ----------------------------------------------------------------
  // counting path
  // ----------------------------------------------------------------
  logic       q2;
  logic       q4;
  logic       lvl;
  logic       ext_rise;
  logic       tmr_tick;
  logic       pre_tick;
  logic [7:0] pre_mask;
  logic       pre_full;
  logic       pre_out;
  logic       samp_pt;
  logic       ext_inc;
  logic       int_inc;
  logic       inc;
  logic       ovf_set;
  logic       flag_clr;

  assign q2  = (phase_q == tmz_pkg::PHASE_Q2);
  assign q4  = (phase_q == tmz_pkg::PHASE_Q4);
  assign lvl = external_count_input ^ edge_fall;
  assign ext_rise = lvl & ~lvl_prev_q;
  // timer ticks die in sleep so nothing can overflow there
  assign tmr_tick = ~sleep & (src_ext ? ext_rise : q4);
  assign pre_tick = prescaler_assign ? watchdog_tick_in : tmr_tick;
  // timer divides by 2^(n+1), watchdog by 2^n
  assign pre_mask = prescaler_assign ? (8'hff >> 4'(4'h8 - {1'b0, rate}))
                        : (8'hff >> 3'(3'h7 - rate));
  assign pre_full = &(pre_q | ~pre_mask);
  assign pre_out  = prescaler_assign ? lvl : pre_q[rate];
  assign samp_pt  = (q2 | q4) & ~sleep;
  assign ext_inc  = samp_pt & pre_out & ~sync_q;
  assign int_inc  = tmr_tick & (prescaler_assign | pre_full);
  assign inc      = (hold_q == 2'h0) & (src_ext ? ext_inc : int_inc);
  assign ovf_set  = inc & (count_q == 8'hff);
  assign flag_clr = wr_intctl & wdata_q[tmz_pkg::INT_FLAG_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 2'h0;
    end else if (ce) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // match the idle level so reset makes no false edge
      lvl_prev_q <= tmz_pkg::OPTION_RST[tmz_pkg::OPT_EDGE_BIT];
      sync_q     <= tmz_pkg::OPTION_RST[tmz_pkg::OPT_EDGE_BIT];
    end else if (ce) begin
      lvl_prev_q <= lvl;
      if (samp_pt) begin
        sync_q <= pre_out;
      end
    end
  end

  // prescaler is not readable; a count write clears it while it serves the timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= 8'h00;
    end else if (ce) begin
      if (wr_count & ~prescaler_assign) begin
        pre_q <= 8'h00;
      end else if (watchdog_clear_instruction & prescaler_assign) begin
        pre_q <= 8'h00;
      end else if (pre_tick) begin
        pre_q <= pre_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_out_q <= 1'b0;
    end else if (ce) begin
      wdt_out_q <= watchdog_tick_in & (~prescaler_assign | pre_full);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= 2'h0;
    end else if (ce) begin
      if (wr_count) begin
        hold_q <= tmz_pkg::WRITE_HOLD_IC;
      end else if (q4 && hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= tmz_pkg::COUNT_RST;
    end else if (ce) begin
      if (wr_count) begin
        count_q <= wdata_q[7:0];
      end else if (inc) begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // option and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      option_q <= tmz_pkg::OPTION_RST;
    end else if (ce && wr_option) begin
      // moving to the watchdog needs a guard sequence in software
      option_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_en_q <= tmz_pkg::INT_EN_RST;
      flag_q   <= 1'b0;
    end else if (ce) begin
      if (wr_intctl) begin
        int_en_q <= wdata_q[tmz_pkg::INT_EN_BIT];
      end
      // set beats a same-cycle clear; mask never touches the flag
      flag_q <= ovf_set | (flag_q & ~flag_clr);
    end
  end

  assign irq = flag_q & int_en_q;
  assign watchdog_tick_out = wdt_out_q;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= tmz_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_wr) begin
        w_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? tmz_pkg::RESP_OKAY : tmz_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= tmz_pkg::RESP_OKAY;
      rdata_q  <= 32'h0;
    end else if (ce) begin
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_hit ? tmz_pkg::RESP_OKAY : tmz_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          AW'(tmz_pkg::ADDR_COUNT):  rdata_q <= {24'h0, count_q};
          AW'(tmz_pkg::ADDR_OPTION): rdata_q <= {24'h0, option_q};
          AW'(tmz_pkg::ADDR_INTCTL): rdata_q <= {26'h0, int_en_q,
                                                 2'h0, flag_q, 2'h0};
          default:                   rdata_q <= 32'h0;
        endcase
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule // tmz_timer0

// *** tb/tmz_timer0_sva.sv ***
// --------
// checker
// --------
module tmz_chk (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic sleep,
  input logic watchdog_tick_in,
  input logic watchdog_tick_out,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wresp;
    s_wtake ##0 (ce && !s_axi_bvalid) |=> ##1 s_axi_bvalid;
  endproperty
  a_wresp: assert property (p_wresp) else $error("no write answer");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rresp;
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
  endproperty
  a_rresp: assert property (p_rresp) else $error("no read answer");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_arbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arbusy: assert property (p_arbusy) else $error("read taken early");
  // a write may still raise irq in sleep, a tick may not
  property p_sleep;
    $rose(irq) |-> !$past(sleep) || s_axi_bvalid;
  endproperty
  a_sleep: assert property (p_sleep) else $error("irq rose in sleep");
  property p_fall;
    $fell(irq) |-> s_axi_bvalid;
  endproperty
  a_fall: assert property (p_fall) else $error("irq fell alone");
  property p_wdog;
    watchdog_tick_out && $past(ce) |-> $past(watchdog_tick_in);
  endproperty
  a_wdog: assert property (p_wdog) else $error("stray wdog tick");
endmodule // tmz_chk

// *** tb/tmz_ext_src.sv ***
// --------
// external count source
// --------
module tmz_ext_src (
  input  logic clk,
  input  logic rst,
  input  logic en,
  input  int   hp,
  output logic pin,
  output int   rises,
  output int   falls
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // stands still while disabled, so no stray edges between runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin <= 1'b0;
      cnt <= 0;
      rises <= 0;
      falls <= 0;
    end else if (en) begin
      if (cnt >= hp - 1) begin
        cnt <= 0;
        pin <= !pin;
        rises <= rises + (pin ? 0 : 1);
        falls <= falls + (pin ? 1 : 0);
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // tmz_ext_src

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // signals
  // --------
  logic        clk, rst, ce, sleep, ext_en, irq, external_count_input;
  logic        watchdog_tick_in, watchdog_clear_instruction;
  logic        watchdog_tick_out, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, last;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          hp, rises, falls, err_count, checked, i;

  tmz_timer0 i_tmz_timer0 (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_input,
    .sleep, .watchdog_tick_in, .watchdog_clear_instruction,
    .watchdog_tick_out, .irq);
  tmz_ext_src i_tmz_ext_src (.clk, .rst, .en(ext_en), .hp,
    .pin(external_count_input), .rises, .falls);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  always @(posedge clk) begin
    watchdog_tick_in <= $urandom_range(0, 7) == 0;
    watchdog_clear_instruction <= $urandom_range(0, 63) == 0;
  end
  // --------
  // tasks
  // --------
  task automatic conclude();
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic expire();
    err_count++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic near(input logic [31:0] g, input int e, input int t);
    chk((!$isunknown(g) && int'(g) - e <= t && e - int'(g) <= t) ? e : g,
        e);
  endtask
  // op bit 0 selects write, bit 1 skips the read data compare
  task automatic bus(input logic [1:0] op, input logic [11:0] a,
                     input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tr, v;
    logic [1:0] r;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= op[0];
    s_axi_wvalid <= op[0];
    s_axi_bready <= op[0];
    s_axi_arvalid <= !op[0];
    s_axi_rready <= !op[0];
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      v = op[0] ? s_axi_bvalid : s_axi_rvalid;
      last = s_axi_rdata;
      r = op[0] ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (v) break;
    end
    if (n == 50) expire();
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk(r, er);
    if (op == 2'b00) chk(last, {24'h0, d});
  endtask
  task automatic run_t(input int i);
    int n, d;
    logic [7:0] v;
    d = (i == 8) ? 1 : 2 << i;
    v = (i == 8) ? 8'($urandom_range(240, 255)) : 8'hff;
    @(posedge clk);
    sleep <= 1'b1;
    bus(2'b01, tmz_pkg::ADDR_OPTION, (i == 8) ? 8'h08 : 8'(i), 2'h0);
    bus(2'b01, tmz_pkg::ADDR_COUNT, v, 2'h0);
    bus(2'b01, tmz_pkg::ADDR_INTCTL, 8'h24, 2'h0);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b0);
    bus(2'b00, tmz_pkg::ADDR_COUNT, v, 2'h0);
    sleep <= 1'b0;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (irq === 1'b1) break;
    end
    if (n == 3000) expire();
    near(n, 4 * (256 - v) * d - 2, 2);
  endtask
  task automatic run_x(input logic e, input logic a);
    int k;
    hp <= $urandom_range(3, 6);
    bus(2'b01, tmz_pkg::ADDR_OPTION, {3'h1, e, a, 3'h0}, 2'h0);
    bus(2'b01, tmz_pkg::ADDR_COUNT, 8'h00, 2'h0);
    repeat (16) @(posedge clk);
    k = e ? falls : rises;
    ext_en <= 1'b1;
    repeat ($urandom_range(40, 160)) @(posedge clk);
    ext_en <= 1'b0;
    repeat (16) @(posedge clk);
    k = (e ? falls : rises) - k;
    bus(2'b10, tmz_pkg::ADDR_COUNT, 8'h00, 2'h0);
    near(last, a ? k : k / 2, 1);
  endtask
  // --------
  // main sequence
  // --------
  initial begin
    void'($urandom(28365));
    rst = 1'b1;
    ce = 1'b1;
    {sleep, ext_en, watchdog_tick_in, watchdog_clear_instruction} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    hp = 3;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(2'b00, tmz_pkg::ADDR_OPTION, 8'hff, 2'h0);
    bus(2'b00, tmz_pkg::ADDR_COUNT, 8'h00, 2'h0);
    bus(2'b00, tmz_pkg::ADDR_INTCTL, 8'h00, 2'h0);
    bus(2'b00, 12'h008, 8'h00, 2'h2);
    bus(2'b01, 12'h008, 8'h5a, 2'h2);
    for (i = 0; i < 9; i++) run_t(i);
    bus(2'b01, tmz_pkg::ADDR_INTCTL, 8'h00, 2'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    bus(2'b00, tmz_pkg::ADDR_INTCTL, 8'h04, 2'h0);
    bus(2'b01, tmz_pkg::ADDR_INTCTL, 8'h04, 2'h0);
    bus(2'b00, tmz_pkg::ADDR_INTCTL, 8'h00, 2'h0);
    bus(2'b01, tmz_pkg::ADDR_COUNT, 8'h10, 2'h0);
    bus(2'b00, tmz_pkg::ADDR_COUNT, 8'h10, 2'h0);
    bus(2'b00, tmz_pkg::ADDR_COUNT, 8'h10, 2'h0);
    for (i = 0; i < 4; i++) run_x(i[0], i[1]);
    conclude();
  end
endmodule // tb_top

bind tmz_timer0 tmz_chk i_tmz_chk (.clk, .rst, .ce, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .sleep, .watchdog_tick_in, .watchdog_tick_out, .irq);
